//--- atu_consts.svh
`ifndef ATU_CONSTS_SVH
`define ATU_CONSTS_SVH
// register byte offsets
`define ATU_OFS_CTRL 12'h000
`define ATU_OFS_FLAGS 12'h004
`define ATU_OFS_CAUSE 12'h008
`define ATU_OFS_VEC 12'h00c
`define ATU_OFS_RETPC 12'h010
`define ATU_OFS_STAT 12'h014
// ctrl field positions
`define ATU_C_IVE 0
`define ATU_C_DZE 1
`define ATU_C_FE 2
`define ATU_C_FUE 3
`define ATU_C_INE 4
`define ATU_C_TR 5
`define ATU_C_SEQ 6
`define ATU_C_TTC 7
// flag positions
`define ATU_F_AIV 0
`define ATU_F_SIV 1
`define ATU_F_ADZ 2
`define ATU_F_SDZ 3
`define ATU_F_FDZ 4
`define ATU_F_OV 5
`define ATU_F_UN 6
`define ATU_F_RO 7
`define ATU_F_FIN 8
// handler pointer addresses
`define ATU_VEC_ARITH 32'h0000_0044
`define ATU_VEC_TRACE 32'h0000_0040
// cause byte values
`define ATU_CLS_ITRACE 8'h00
`define ATU_CLS_TTC 8'h04
`define ATU_CLS_TINIT 8'h08
`define ATU_Q_CREATE 8'h00
`define ATU_Q_JOIN 8'h01
`define ATU_Q_WFORK 8'h02
`define ATU_Q_IDLE 8'h03
// native reserved operand, ieee specials, mul64 kept bits and bus responses
`define ATU_ROP 64'h8000_0000_0000_0000
`define ATU_NAN 64'h7ff8_0000_0000_0000
`define ATU_INF 64'h7ff0_0000_0000_0000
`define ATU_MUL_OK 53
`define ATU_RESP_OK 2'b00
`define ATU_RESP_ERR 2'b10
`endif

//--- atu_pkg.sv
package atu_pkg;
  typedef enum logic [2:0] {
    ATU_IDLE = 3'b000,
    ATU_DRAIN = 3'b001,
    ATU_PUSH = 3'b011,
    ATU_VECT = 3'b010
  } atu_state_e;
  // arithmetic op report from the execution units
  typedef struct packed {
    logic valid;
    logic ieee;
    logic scalar;
    logic is_float;
    logic ovf;
    logic divzero;
    logic exp_ovf;
    logic exp_unf;
    logic mul64;
    logic intrinsic_err;
    logic [63:0] in_a;
    logic [63:0] in_b;
    logic [63:0] raw_result;
    logic [63:0] dividend;
  } atu_op_s;
  // thread events from the sequencer
  typedef struct packed {
    logic retired;
    logic [31:0] next_pc;
    logic join_op;
    logic wfork_op;
    logic idle_op;
    logic fork_taken;
    logic fork_watch;
    logic fork_init;
    logic [31:0] fork_pc;
  } atu_thr_s;
endpackage : atu_pkg

//--- atu_trap_unit.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "atu_consts.svh"
module atu_trap_unit
  import atu_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire atu_op_s i_op,
  input wire atu_thr_s i_thr,
  input wire logic i_pipe_empty,
  input wire logic i_mach_exc,
  input wire logic i_sys_exc,
  input wire logic i_intr_pend,
  input wire logic i_frame_done,
  output logic [63:0] o_result,
  output logic o_stop_issue,
  output logic o_push_frame,
  output logic o_clear_sw,
  output logic [31:0] o_ret_pc,
  output logic [31:0] o_vec_addr,
  output logic o_vector,
  output logic [1:0] o_exc_class,
  output logic o_keep_thread,
  output logic [31:0] o_cause,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // native reserved operand: sign 1, exponent 0
  function automatic logic is_rop(input logic [63:0] v);
    is_rop = v[63] && (v[62:52] == 11'h000);
  endfunction : is_rop

  // ieee nan or infinity: exponent all ones
  function automatic logic is_special(input logic [63:0] v);
    is_special = (v[62:52] == 11'h7ff);
  endfunction : is_special

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [8:0] flags_r, flags_nxt;
  logic [31:0] cause_r, cause_nxt;
  logic [31:0] vec_r, vec_nxt;
  logic [31:0] retpc_r, retpc_nxt;
  logic [63:0] res_r, res_nxt;
  logic [1:0] cls_r, cls_nxt;
  logic stop_r, stop_nxt, push_r, push_nxt, clr_r, clr_nxt;
  logic vecp_r, vecp_nxt, keep_r, keep_nxt;
  atu_state_e st_r, st_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt;
  logic [11:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic ar_r, ar_nxt, r_r, r_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;

  logic [8:0] ev;
  logic [8:0] en_mask;
  logic trap_req;
  logic a_rop, a_spec;

  // per-op flag events and result substitution
  always_comb begin
    ev = 9'h000;
    res_nxt = res_r;
    a_rop = !i_op.ieee && (is_rop(i_op.in_a) || is_rop(i_op.in_b));
    a_spec = i_op.ieee && (is_special(i_op.in_a) ||
                           is_special(i_op.in_b));
    if (i_op.valid) begin
      res_nxt = i_op.raw_result;
      if (i_op.ovf && !i_op.is_float) begin
        ev[i_op.scalar ? `ATU_F_SIV : `ATU_F_AIV] = 1'b1;
        if (i_op.mul64) begin
          res_nxt = {{(64-`ATU_MUL_OK){1'b0}},
                     i_op.raw_result[`ATU_MUL_OK-1:0]};
        end
      end
      if (i_op.divzero && !i_op.is_float) begin
        ev[i_op.scalar ? `ATU_F_SDZ : `ATU_F_ADZ] = 1'b1;
        res_nxt = i_op.dividend;
      end
      if (i_op.divzero && i_op.is_float) begin
        ev[`ATU_F_FDZ] = 1'b1;
        res_nxt = i_op.ieee ? `ATU_NAN : `ATU_ROP;
      end
      if (i_op.exp_ovf) begin
        ev[`ATU_F_OV] = 1'b1;
        res_nxt = i_op.ieee ? `ATU_INF : `ATU_ROP;
      end
      if (i_op.exp_unf) begin
        ev[`ATU_F_UN] = 1'b1;
        res_nxt = 64'h0000_0000_0000_0000;
      end
      if (a_rop && i_op.is_float) begin
        ev[`ATU_F_RO] = 1'b1;
        res_nxt = `ATU_ROP;
      end
      if (a_spec && i_op.is_float) begin
        ev[`ATU_F_RO] = 1'b1;
      end
      if (i_op.intrinsic_err) begin
        ev[`ATU_F_FIN] = 1'b1;
      end
    end
  end

  always_comb begin
    en_mask = 9'h000;
    en_mask[`ATU_F_AIV] = ctrl_r[`ATU_C_IVE];
    en_mask[`ATU_F_SIV] = ctrl_r[`ATU_C_IVE];
    en_mask[`ATU_F_ADZ] = ctrl_r[`ATU_C_DZE];
    en_mask[`ATU_F_SDZ] = ctrl_r[`ATU_C_DZE];
    en_mask[`ATU_F_OV] = ctrl_r[`ATU_C_FE];
    en_mask[`ATU_F_RO] = ctrl_r[`ATU_C_FE];
    en_mask[`ATU_F_FDZ] = ctrl_r[`ATU_C_FE];
    en_mask[`ATU_F_UN] = ctrl_r[`ATU_C_FUE];
    en_mask[`ATU_F_FIN] = ctrl_r[`ATU_C_INE];
  end
  assign trap_req = |(flags_r & en_mask);

  // trap sequencer and bus slave next state
  always_comb begin
    st_nxt = st_r;
    flags_nxt = flags_r;
    ctrl_nxt = ctrl_r;
    cause_nxt = cause_r;
    vec_nxt = vec_r;
    retpc_nxt = retpc_r;
    cls_nxt = cls_r;
    stop_nxt = stop_r;
    push_nxt = 1'b0;
    clr_nxt = 1'b0;
    vecp_nxt = 1'b0;
    keep_nxt = keep_r;
    aw_nxt = aw_r;
    w_nxt = w_r;
    b_nxt = b_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    ar_nxt = 1'b0;
    r_nxt = r_r;
    rd_nxt = rd_r;
    bresp_nxt = bresp_r;
    rresp_nxt = rresp_r;
    // write address and data taken in either order
    if (s_axi_awvalid && !aw_r && !b_r) begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r && !b_r) begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
    end
    if (aw_r && w_r && !b_r) begin
      b_nxt = 1'b1;
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bresp_nxt = `ATU_RESP_OK;
      case (awa_r)
        `ATU_OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            ctrl_nxt = wd_r[7:0];
          end
        end
        `ATU_OFS_FLAGS: begin
          flags_nxt = flags_r & ~wd_r[8:0];
        end
        `ATU_OFS_CAUSE, `ATU_OFS_VEC, `ATU_OFS_RETPC,
        `ATU_OFS_STAT: begin
          bresp_nxt = `ATU_RESP_OK;
        end
        default: begin
          bresp_nxt = `ATU_RESP_ERR;
        end
      endcase
    end
    if (b_r && s_axi_bready) begin
      b_nxt = 1'b0;
    end
    // readys registered so the ports come from flops
    awrdy_nxt = !aw_nxt && !b_nxt;
    wrdy_nxt = !w_nxt && !b_nxt;
    flags_nxt = flags_nxt | ev;
    // ready offered for one cycle; data only after the handshake
    if (s_axi_arvalid && !r_r && !ar_r) begin
      ar_nxt = 1'b1;
    end
    if (s_axi_arvalid && ar_r) begin
      r_nxt = 1'b1;
      rresp_nxt = `ATU_RESP_OK;
      case (s_axi_araddr)
        `ATU_OFS_CTRL: rd_nxt = {24'h000000, ctrl_r};
        `ATU_OFS_FLAGS: rd_nxt = {23'h000000, flags_r};
        `ATU_OFS_CAUSE: rd_nxt = cause_r;
        `ATU_OFS_VEC: rd_nxt = vec_r;
        `ATU_OFS_RETPC: rd_nxt = retpc_r;
        `ATU_OFS_STAT: rd_nxt = {29'h00000000, st_r};
        default: begin
          rd_nxt = 32'h0000_0000;
          rresp_nxt = `ATU_RESP_ERR;
        end
      endcase
    end
    if (r_r && s_axi_rready) begin
      r_nxt = 1'b0;
    end
    case (st_r)
      ATU_IDLE: begin
        keep_nxt = 1'b0;
        if (i_mach_exc) begin
          cls_nxt = 2'b11;
        end else if (i_sys_exc) begin
          cls_nxt = 2'b10;
        end else if (trap_req) begin
          stop_nxt = 1'b1;
          cls_nxt = 2'b01;
          vec_nxt = `ATU_VEC_ARITH;
          st_nxt = ATU_DRAIN;
        end else if (i_thr.retired && ctrl_r[`ATU_C_TR]) begin
          stop_nxt = 1'b1;
          cls_nxt = 2'b01;
          vec_nxt = `ATU_VEC_TRACE;
          cause_nxt = {`ATU_CLS_ITRACE, 8'h00, 16'h0000};
          retpc_nxt = i_thr.next_pc;
          st_nxt = ATU_DRAIN;
        end else if (i_thr.retired && ctrl_r[`ATU_C_TTC] &&
                     (i_thr.join_op || i_thr.wfork_op ||
                      i_thr.idle_op)) begin
          // trap before idle loop, keep thread
          stop_nxt = 1'b1;
          keep_nxt = 1'b1;
          cls_nxt = 2'b01;
          vec_nxt = `ATU_VEC_TRACE;
          cause_nxt = {i_thr.join_op ? `ATU_Q_JOIN :
                       i_thr.wfork_op ? `ATU_Q_WFORK : `ATU_Q_IDLE,
                       `ATU_CLS_TTC, 16'h0000};
          retpc_nxt = i_thr.next_pc;
          st_nxt = ATU_DRAIN;
        end else if (i_thr.fork_taken &&
                     (i_thr.fork_watch || i_thr.fork_init)) begin
          stop_nxt = 1'b1;
          cls_nxt = 2'b01;
          vec_nxt = `ATU_VEC_TRACE;
          cause_nxt = i_thr.fork_watch ?
                      {`ATU_Q_CREATE, `ATU_CLS_TTC, 16'h0000} :
                      {8'h00, `ATU_CLS_TINIT, 16'h0000};
          retpc_nxt = i_thr.fork_pc;
          st_nxt = ATU_DRAIN;
        end else begin
          cls_nxt = 2'b00;
        end
        if (trap_req && !i_mach_exc && !i_sys_exc) begin
          retpc_nxt = i_thr.next_pc;
        end
      end
      ATU_DRAIN: begin
        if (i_pipe_empty && !i_intr_pend && !i_mach_exc &&
            !i_sys_exc) begin
          push_nxt = 1'b1;
          st_nxt = ATU_PUSH;
        end
      end
      ATU_PUSH: begin
        push_nxt = !i_frame_done;
        if (i_frame_done) begin
          clr_nxt = (vec_r == `ATU_VEC_ARITH);
          st_nxt = ATU_VECT;
        end
      end
      ATU_VECT: begin
        vecp_nxt = 1'b1;
        stop_nxt = 1'b0;
        if (vec_r == `ATU_VEC_ARITH) begin
          flags_nxt = ev;
        end
        st_nxt = ATU_IDLE;
      end
      default: begin
        st_nxt = ATU_IDLE;
      end
    endcase
  end

  // register all state
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= ATU_IDLE;
      ctrl_r <= 8'h00;
      flags_r <= 9'h000;
      cause_r <= 32'h0000_0000;
      vec_r <= 32'h0000_0000;
      retpc_r <= 32'h0000_0000;
      res_r <= 64'h0000_0000_0000_0000;
      cls_r <= 2'b00;
      stop_r <= 1'b0;
      push_r <= 1'b0;
      clr_r <= 1'b0;
      vecp_r <= 1'b0;
      keep_r <= 1'b0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      b_r <= 1'b0;
      awa_r <= 12'h000;
      wd_r <= 32'h0000_0000;
      ar_r <= 1'b0;
      r_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      bresp_r <= 2'b00;
      rresp_r <= 2'b00;
      awrdy_r <= 1'b1;
      wrdy_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      flags_r <= flags_nxt;
      cause_r <= cause_nxt;
      vec_r <= vec_nxt;
      retpc_r <= retpc_nxt;
      res_r <= res_nxt;
      cls_r <= cls_nxt;
      stop_r <= stop_nxt;
      push_r <= push_nxt;
      clr_r <= clr_nxt;
      vecp_r <= vecp_nxt;
      keep_r <= keep_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      b_r <= b_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ar_r <= ar_nxt;
      r_r <= r_nxt;
      rd_r <= rd_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      awrdy_r <= awrdy_nxt;
      wrdy_r <= wrdy_nxt;
    end
  end

  // outputs straight from flops
  assign o_result = res_r;
  assign o_stop_issue = stop_r;
  assign o_push_frame = push_r;
  assign o_clear_sw = clr_r;
  assign o_ret_pc = retpc_r;
  assign o_vec_addr = vec_r;
  assign o_vector = vecp_r;
  assign o_exc_class = cls_r;
  assign o_keep_thread = keep_r;
  assign o_cause = cause_r;
  // ready only while slot free, so no write is lost
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready = wrdy_r;
  assign s_axi_bvalid = b_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ar_r;
  assign s_axi_rvalid = r_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = rresp_r;

  chk_push_drained: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    (st_r == ATU_DRAIN && st_nxt == ATU_PUSH) |-> i_pipe_empty)
    else $error("frame pushed before drain");
  chk_flag_sticky: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    (flags_r[`ATU_F_UN] && !(b_r == 1'b0 && aw_r && w_r) &&
     st_r == ATU_IDLE) |=> flags_r[`ATU_F_UN])
    else $error("flag lost");
  chk_unf_zero: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    (i_op.valid && i_op.exp_unf && !i_op.divzero && !a_rop) |=>
    (o_result == 64'h0 && flags_r[`ATU_F_UN]))
    else $error("underflow not zeroed");
  chk_div_dividend: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    (i_op.valid && i_op.divzero && !i_op.is_float &&
     !i_op.exp_ovf && !i_op.exp_unf) |=> o_result == $past(i_op.dividend))
    else $error("quotient not dividend");
  chk_stop_drain: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    (st_r == ATU_DRAIN) |-> o_stop_issue)
    else $error("issue not stopped");
  chk_arith_vec: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    (st_r == ATU_IDLE && trap_req && !i_mach_exc && !i_sys_exc) |=>
    (o_vec_addr == `ATU_VEC_ARITH))
    else $error("wrong arith vector");
  chk_clear_sw: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    o_clear_sw |-> $past(st_r) == ATU_PUSH)
    else $error("clear out of order");
  chk_mach_prio: assert property (@(posedge i_mclk)
    disable iff (!i_rst_b)
    (st_r == ATU_IDLE && i_mach_exc) |=> o_exc_class == 2'b11)
    else $error("machine not first");
endmodule : atu_trap_unit
`default_nettype wire

//--- atu_trap_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "atu_consts.svh"
module atu_trap_unit_tb
  import atu_pkg::*;
;
  localparam logic [63:0] all_m = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] m53 = 64'h001f_ffff_ffff_ffff;
  logic i_mclk = 1'b0;
  logic i_rst_b;
  atu_op_s i_op;
  atu_thr_s i_thr;
  logic i_pipe_empty, i_mach_exc, i_sys_exc, i_intr_pend, i_frame_done;
  logic [63:0] o_result;
  logic o_stop_issue, o_push_frame, o_clear_sw, o_vector, o_keep_thread;
  logic [31:0] o_ret_pc, o_vec_addr, o_cause;
  logic [1:0] o_exc_class;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int n_mismatch = 0;
  int n_checks = 0;
  atu_op_s b, op;
  atu_op_s gop [5];
  logic [63:0] gexp [5];
  int gbit [5];
  atu_thr_s t;
  logic [31:0] rd;
  logic [1:0] rr;

  // 250 mhz clock
  always #2 i_mclk = ~i_mclk;

  atu_trap_unit dut (
    .i_mclk, .i_rst_b, .i_op, .i_thr, .i_pipe_empty, .i_mach_exc,
    .i_sys_exc, .i_intr_pend, .i_frame_done, .o_result, .o_stop_issue,
    .o_push_frame, .o_clear_sw, .o_ret_pc, .o_vec_addr, .o_vector,
    .o_exc_class, .o_keep_thread, .o_cause,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick

  // outputs are looked at mid-cycle, away from the launching edge
  task automatic settle;
    @(negedge i_mclk);
  endtask : settle

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge i_mclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge i_mclk);
  endtask : axi_rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", r, `ATU_RESP_OK);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input string nm);
    axi_rd(a, rd, rr);
    chk(nm, rd, e);
  endtask : rd_chk

  // one op report, then its result, flag and issue state
  task automatic run_op(input atu_op_s o, input logic [63:0] e,
                        input logic [63:0] m, input int bi,
                        input logic trap);
    o.valid = 1'b1;
    i_op <= o;
    @(posedge i_mclk);
    i_op.valid <= 1'b0;
    settle();
    chk("result", o_result & m, e & m);
    @(posedge i_mclk);
    axi_rd(`ATU_OFS_FLAGS, rd, rr);
    chk("flag", rd[bi], 1'b1);
    chk("stop_issue", o_stop_issue, trap);
    if (trap) chk("push_frame", o_push_frame, 1'b0);
  endtask : run_op

  task automatic thr_ev(input atu_thr_s e);
    i_thr <= e;
    @(posedge i_mclk);
    i_thr <= '0;
  endtask : thr_ev

  // frame push, acknowledge, then the vector jump
  task automatic trap_seq(input logic [31:0] v, input logic [31:0] pc,
                          input logic [31:0] cs, input logic ar,
                          input logic kt);
    int n;
    logic clr;
    n = 0;
    clr = 1'b0;
    do begin
      settle();
      n++;
    end while (o_push_frame !== 1'b1 && n < 50);
    chk("push_frame", o_push_frame, 1'b1);
    chk("vec_addr", o_vec_addr, v);
    chk("exc_class", o_exc_class, 2'd1);
    chk("ret_pc", o_ret_pc, pc);
    if (!ar) chk("cause", o_cause, cs);
    if (kt) chk("keep_thread", o_keep_thread, 1'b1);
    @(posedge i_mclk);
    i_frame_done <= 1'b1;
    @(posedge i_mclk);
    i_frame_done <= 1'b0;
    n = 0;
    do begin
      settle();
      n++;
      clr = clr | o_clear_sw;
    end while (o_vector !== 1'b1 && n < 20);
    chk("vector", o_vector, 1'b1);
    chk("clear_sw", clr, ar);
    @(posedge i_mclk);
  endtask : trap_seq

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_mismatch++;
    print_verdict();
  end

  // main sequence
  initial begin
    i_rst_b = 1'b0;
    i_op = '0;
    i_thr = '0;
    {i_mach_exc, i_sys_exc, i_intr_pend, i_frame_done} = 4'h0;
    i_pipe_empty = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    tick(6);
    settle();
    chk("outs", {o_stop_issue, o_push_frame, o_vector, o_clear_sw}, 0);
    chk("cause", o_cause, 0);
    tick(6);
    i_rst_b <= 1'b1;
    tick(1);
    rd_chk(`ATU_OFS_CTRL, 32'h0, "ctrl");
    rd_chk(`ATU_OFS_FLAGS, 32'h0, "flags");
    axi_rd(12'h020, rd, rr);
    chk("rresp", rr, `ATU_RESP_ERR);
    chk("rdata", rd, 32'h0);
    axi_wr(12'h020, 32'h0000_00ff, rr);
    chk("bresp", rr, `ATU_RESP_ERR);
    wr(`ATU_OFS_CTRL, 32'h0000_005a);
    rd_chk(`ATU_OFS_CTRL, 32'h0000_005a, "ctrl");
    wr(`ATU_OFS_CTRL, 32'h0);
    // every trap masked: results and flags only
    b = '0;
    b.raw_result = 64'h0123_4567_89ab_cdef;
    b.dividend = 64'h1111_2222_3333_4444;
    b.in_a = 64'h4000_0000_0000_0000;
    b.in_b = 64'h4000_0000_0000_0000;
    op = b;
    op.ovf = 1'b1;
    run_op(op, b.raw_result, all_m, `ATU_F_AIV, 1'b0);
    op.scalar = 1'b1;
    run_op(op, b.raw_result, all_m, `ATU_F_SIV, 1'b0);
    op = b;
    op.ovf = 1'b1;
    op.mul64 = 1'b1;
    run_op(op, b.raw_result, m53, `ATU_F_AIV, 1'b0);
    op = b;
    op.divzero = 1'b1;
    run_op(op, b.dividend, all_m, `ATU_F_ADZ, 1'b0);
    op.scalar = 1'b1;
    run_op(op, b.dividend, all_m, `ATU_F_SDZ, 1'b0);
    op = b;
    op.is_float = 1'b1;
    op.divzero = 1'b1;
    run_op(op, `ATU_ROP, all_m, `ATU_F_FDZ, 1'b0);
    op.ieee = 1'b1;
    run_op(op, `ATU_NAN, all_m, `ATU_F_FDZ, 1'b0);
    op = b;
    op.is_float = 1'b1;
    op.exp_ovf = 1'b1;
    run_op(op, `ATU_ROP, all_m, `ATU_F_OV, 1'b0);
    op.ieee = 1'b1;
    run_op(op, `ATU_INF, all_m, `ATU_F_OV, 1'b0);
    op = b;
    op.is_float = 1'b1;
    op.exp_unf = 1'b1;
    run_op(op, 64'h0, all_m, `ATU_F_UN, 1'b0);
    op = b;
    op.is_float = 1'b1;
    op.in_a = 64'h8000_0000_0000_1234;
    run_op(op, `ATU_ROP, all_m, `ATU_F_RO, 1'b0);
    op = b;
    op.is_float = 1'b1;
    op.ieee = 1'b1;
    op.in_b = `ATU_INF;
    run_op(op, 64'h0, 64'h0, `ATU_F_RO, 1'b0);
    op.in_b = `ATU_NAN;
    run_op(op, 64'h0, 64'h0, `ATU_F_RO, 1'b0);
    op = b;
    op.intrinsic_err = 1'b1;
    run_op(op, 64'h0, 64'h0, `ATU_F_FIN, 1'b0);
    // all nine stay set together until cleared, bit 0 first, then the other eight at once
    rd_chk(`ATU_OFS_FLAGS, 32'h0000_01ff, "flags");
    wr(`ATU_OFS_FLAGS, 32'h0000_0001);
    rd_chk(`ATU_OFS_FLAGS, 32'h0000_01fe, "flags");
    wr(`ATU_OFS_FLAGS, 32'h0000_01fe);
    rd_chk(`ATU_OFS_FLAGS, 32'h0, "flags");
    // one enabled group at a time, drain and interrupt hold it off
    for (int g = 0; g < 5; g++) begin
      gop[g] = b;
      gexp[g] = 64'h0;
    end
    gop[0].ovf = 1'b1;
    gexp[0] = b.raw_result;
    gbit[0] = `ATU_F_AIV;
    gop[1].divzero = 1'b1;
    gexp[1] = b.dividend;
    gbit[1] = `ATU_F_ADZ;
    gop[2].is_float = 1'b1;
    gop[2].exp_ovf = 1'b1;
    gexp[2] = `ATU_ROP;
    gbit[2] = `ATU_F_OV;
    gop[3].is_float = 1'b1;
    gop[3].exp_unf = 1'b1;
    gbit[3] = `ATU_F_UN;
    gop[4].intrinsic_err = 1'b1;
    gbit[4] = `ATU_F_FIN;
    i_thr.next_pc <= 32'h0000_5000;
    for (int g = 0; g < 5; g++) begin
      wr(`ATU_OFS_CTRL, 32'h1 << g);
      i_pipe_empty <= 1'b0;
      run_op(gop[g], gexp[g], (g == 4) ? 64'h0 : all_m, gbit[g], 1'b1);
      i_pipe_empty <= 1'b1;
      i_intr_pend <= 1'b1;
      tick(4);
      settle();
      chk("push_frame", o_push_frame, 1'b0);
      @(posedge i_mclk);
      i_intr_pend <= 1'b0;
      trap_seq(`ATU_VEC_ARITH, 32'h0000_5000, 32'h0, 1'b1, 1'b0);
      rd_chk(`ATU_OFS_FLAGS, 32'h0, "flags");
      chk("stop_issue", o_stop_issue, 1'b0);
    end
    // single step; serial execution set alongside as software must
    wr(`ATU_OFS_CTRL, 32'h0000_0060);
    t = '0;
    t.retired = 1'b1;
    t.next_pc = 32'h0000_1234;
    thr_ev(t);
    trap_seq(`ATU_VEC_TRACE, 32'h0000_1234, 32'h0, 1'b0, 1'b0);
    // thread watch on join, wait-fork and idle
    wr(`ATU_OFS_CTRL, 32'h0000_0080);
    for (int k = 0; k < 3; k++) begin
      t = '0;
      t.retired = 1'b1;
      t.next_pc = 32'h0000_2000 + 32'(4 * k);
      t.join_op = (k == 0);
      t.wfork_op = (k == 1);
      t.idle_op = (k == 2);
      thr_ev(t);
      trap_seq(`ATU_VEC_TRACE, t.next_pc,
               {8'(k + 1), `ATU_CLS_TTC, 16'h0}, 1'b0, 1'b1);
    end
    // handler clears the watch bit and reruns the backed-up join
    wr(`ATU_OFS_CTRL, 32'h0);
    t = '0;
    t.retired = 1'b1;
    t.join_op = 1'b1;
    t.next_pc = 32'h0000_2000;
    thr_ev(t);
    settle();
    chk("stop_issue", o_stop_issue, 1'b0);
    chk("keep_thread", o_keep_thread, 1'b0);
    t = '0;
    t.fork_taken = 1'b1;
    t.fork_watch = 1'b1;
    t.fork_pc = 32'h0000_3000;
    thr_ev(t);
    trap_seq(`ATU_VEC_TRACE, 32'h0000_3000,
             {`ATU_Q_CREATE, `ATU_CLS_TTC, 16'h0}, 1'b0, 1'b0);
    wr(`ATU_OFS_CTRL, 32'h0);
    t.fork_watch = 1'b0;
    t.fork_init = 1'b1;
    t.fork_pc = 32'h0000_4000;
    thr_ev(t);
    trap_seq(`ATU_VEC_TRACE, 32'h0000_4000,
             {8'h00, `ATU_CLS_TINIT, 16'h0}, 1'b0, 1'b0);
    // class ranking with machine and system levels
    for (int i = 0; i < 4; i++) begin
      i_mach_exc <= (i >= 2);
      i_sys_exc <= (i % 2 == 1);
      tick(3);
      settle();
      chk("exc_class", o_exc_class,
          (i >= 2) ? 2'd3 : (i == 1) ? 2'd2 : 2'd0);
      @(posedge i_mclk);
    end
    print_verdict();
  end
endmodule : atu_trap_unit_tb
`default_nettype wire
